/* dtxa_defines.svh */
`ifndef DTXA_DEFINES_SVH
`define DTXA_DEFINES_SVH

// ****************************************
// register map
// ****************************************
`define DTXA_CFG_ADDR 8'h30
`define DTXA_CFG_RESET 8'h07
`define DTXA_RD_ZERO 8'h00

// ****************************************
// field positions in the configuration register
// ****************************************
`define DTXA_BIT_YELLOW 7
`define DTXA_BIT_XHIGH 6
`define DTXA_BIT_IDLE 5
`define DTXA_BIT_AIS 4
`define DTXA_BIT_LOS 3
`define DTXA_BIT_ON_LOS 2
`define DTXA_BIT_ON_OOF 1
`define DTXA_BIT_ON_AIS 0

// ****************************************
// payload fill sequences, first bit in the top position
// ****************************************
`define DTXA_IDLE_SEQ 4'hc
`define DTXA_AIS_SEQ 4'ha

`endif

/* dtxa_liu_model.sv */
`timescale 1ns/1ps
`default_nettype none

// ****
// line interface unit model
// ****
module dtxa_liu_model
(
	input wire logic sys_clk, // line clock
	input wire logic rst, // synchronous clear
	input wire logic line_valid, // bit present
	input wire logic line_data, // line bit
	output logic [15:0] bit_count, // bits received
	output logic idle_marks // mark seen with no bit
);
	// count arrivals; a stray mark between bits would corrupt the receiver
	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			bit_count <= 16'h0000;
			idle_marks <= 1'b0;
		end
		else
		begin
			if (line_valid)
				bit_count <= bit_count + 16'h0001;
			if (!line_valid && line_data)
				idle_marks <= 1'b1;
		end
	end
endmodule

`default_nettype wire

/* dtxa_override.sv */
// Summary of operation
// - yellow force bit zeroes every outbound X-bit; clear means receive-derived X-bits.
// - yellow force has no effect under loss-of-signal, AIS or idle commands.
// - X-high force bit drives every outbound X-bit to one.
// - X-high force ignored under loss-of-signal, AIS, idle or yellow force.
// - idle keeps M/F/P, zeroes F-frame 3 CP bits, X ones, payload 1100 repeating.
// - idle command ignored while loss-of-signal or AIS command is set.
// - AIS keeps M/F/P, all C-bits zero, X-bits one, payload 1010 repeating.
// - loss-of-signal command sends continuous zeros; clearing restores normal frames.
// - without idle or AIS, normal frames carry user payload and own overhead.
// - enable sends yellow alarm while near-end receiver reports loss of signal.
// - enable sends yellow alarm while near-end receiver reports out-of-frame.
// - enable sends yellow alarm while near-end receiver reports AIS.
`timescale 1ns/1ps
`default_nettype none
`include "dtxa_defines.svh"

module dtxa_override
#(
	parameter int ADDR_W = 8 // processor address width
)
(
	input wire logic sys_clk, // 250 MHz clock
	input wire logic rst, // synchronous reset, high
	input wire logic reg_wr_en, // register write strobe
	input wire logic reg_rd_en, // register read strobe
	input wire logic [ADDR_W-1:0] reg_addr, // register address
	input wire logic [7:0] reg_wr_data, // write data
	output logic [7:0] reg_rd_data, // read data, one cycle after strobe
	input wire logic rx_los, // near-end receiver loss of signal
	input wire logic rx_oof, // near-end receiver out of frame
	input wire logic rx_ais, // near-end receiver AIS detected
	input wire logic tx_bit_valid, // outbound bit present
	input wire logic tx_bit_in, // outbound bit from framer
	input wire dtxa_pkg::dtxa_kind_t tx_bit_kind, // class of that bit
	output logic tx_line_valid, // line bit present
	output logic tx_line_data, // line bit toward the interface unit
	output logic tx_yellow_active // X-bits currently carry yellow
);
	import dtxa_pkg::*;

	// ****************************************
	// parameter check
	// ****************************************
	// the map needs at least the 0x30 decode
	if (ADDR_W < 6)
	begin : g_bad_addr
		$error("ADDR_W too small for the register map");
	end

	// ****************************************
	// state
	// ****************************************
	logic [7:0] cfg_reg;
	logic [1:0] pat_cnt_reg;
	logic line_data_next;
	logic auto_yellow;
	logic x_normal;
	dtxa_mode_t mode_sel;

	// picks the bit of a four-bit fill sequence for this payload slot
	function automatic logic pat_bit(input logic [3:0] seq, input logic [1:0] idx);
		pat_bit = seq[2'h3 - idx];
	endfunction

	// ****************************************
	// register access
	// ****************************************
	// configuration register write, full byte
	always_ff @(posedge sys_clk)
	begin
		if (rst)
			cfg_reg <= `DTXA_CFG_RESET;
		else if (reg_wr_en && reg_addr == ADDR_W'(`DTXA_CFG_ADDR))
			cfg_reg <= reg_wr_data;
	end

	// read path; unmapped addresses read zero
	always_ff @(posedge sys_clk)
	begin
		if (rst)
			reg_rd_data <= `DTXA_RD_ZERO;
		else if (reg_rd_en)
			reg_rd_data <= (reg_addr == ADDR_W'(`DTXA_CFG_ADDR)) ? cfg_reg : `DTXA_RD_ZERO;
	end

	// ****************************************
	// mode selection
	// ****************************************
	// fixed priority: zeros, then AIS, then idle
	always_comb
	begin
		if (cfg_reg[`DTXA_BIT_LOS])
			mode_sel = DTXA_MODE_LOS;
		else if (cfg_reg[`DTXA_BIT_AIS])
			mode_sel = DTXA_MODE_AIS;
		else if (cfg_reg[`DTXA_BIT_IDLE])
			mode_sel = DTXA_MODE_IDLE;
		else
			mode_sel = DTXA_MODE_NORMAL;
	end

	// ****************************************
	// X-bit generation
	// ****************************************
	// yellow on loss of signal, out-of-frame or AIS, each with its own enable
	assign auto_yellow = (cfg_reg[`DTXA_BIT_ON_LOS] && rx_los)
		|| (cfg_reg[`DTXA_BIT_ON_OOF] && rx_oof)
		|| (cfg_reg[`DTXA_BIT_ON_AIS] && rx_ais);

	// forced yellow outranks forced high; only used in normal mode
	always_comb
	begin
		if (cfg_reg[`DTXA_BIT_YELLOW])
			x_normal = 1'b0;
		else if (cfg_reg[`DTXA_BIT_XHIGH])
			x_normal = 1'b1;
		else
			x_normal = ~auto_yellow;
	end

	// ****************************************
	// payload fill position
	// ****************************************
	// runs on payload bits only so overhead does not break the sequence
	always_ff @(posedge sys_clk)
	begin
		if (rst)
			pat_cnt_reg <= 2'h0;
		else if (tx_bit_valid && tx_bit_kind == DTXA_KIND_PAYLOAD)
			pat_cnt_reg <= pat_cnt_reg + 2'h1;
	end

	// ****************************************
	// outbound bit selection
	// ****************************************
	always_comb
	begin
		line_data_next = tx_bit_in;
		case (mode_sel)
			DTXA_MODE_LOS:
			begin
				line_data_next = 1'b0;
			end
			DTXA_MODE_AIS:
			begin
				case (tx_bit_kind)
					DTXA_KIND_MFP: line_data_next = tx_bit_in;
					DTXA_KIND_X: line_data_next = 1'b1;
					DTXA_KIND_C: line_data_next = 1'b0;
					DTXA_KIND_CP: line_data_next = 1'b0;
					DTXA_KIND_PAYLOAD: line_data_next = pat_bit(`DTXA_AIS_SEQ, pat_cnt_reg);
					default: line_data_next = 1'b0;
				endcase
			end
			DTXA_MODE_IDLE:
			begin
				case (tx_bit_kind)
					DTXA_KIND_MFP: line_data_next = tx_bit_in;
					DTXA_KIND_X: line_data_next = 1'b1;
					DTXA_KIND_C: line_data_next = tx_bit_in;
					DTXA_KIND_CP: line_data_next = 1'b0;
					DTXA_KIND_PAYLOAD: line_data_next = pat_bit(`DTXA_IDLE_SEQ, pat_cnt_reg);
					default: line_data_next = 1'b0;
				endcase
			end
			DTXA_MODE_NORMAL:
			begin
				if (tx_bit_kind == DTXA_KIND_X)
					line_data_next = x_normal;
				else
					line_data_next = tx_bit_in;
			end
			default: line_data_next = 1'b0;
		endcase
	end

	// ****************************************
	// line output registers
	// ****************************************
	// one cycle of latency keeps the line bit glitch free
	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			tx_line_valid <= 1'b0;
			tx_line_data <= 1'b0;
		end
		else
		begin
			tx_line_valid <= tx_bit_valid;
			tx_line_data <= tx_bit_valid ? line_data_next : 1'b0;
		end
	end

	// status view of what the X-bits carry
	always_ff @(posedge sys_clk)
	begin
		if (rst)
			tx_yellow_active <= 1'b0;
		else
			tx_yellow_active <= (mode_sel == DTXA_MODE_NORMAL) && !x_normal;
	end

	// ****************************************
	// assertions
	// ****************************************
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);

	logic c_los, c_ais, c_idle, c_yel, c_xhi;
	assign c_los = cfg_reg[`DTXA_BIT_LOS];
	assign c_ais = cfg_reg[`DTXA_BIT_AIS];
	assign c_idle = cfg_reg[`DTXA_BIT_IDLE];
	assign c_yel = cfg_reg[`DTXA_BIT_YELLOW];
	assign c_xhi = cfg_reg[`DTXA_BIT_XHIGH];

	sequence s_zero_out;
		##1 tx_line_valid && !tx_line_data;
	endsequence
	sequence s_one_out;
		##1 tx_line_valid && tx_line_data;
	endsequence
	sequence s_pass_out;
		##1 tx_line_valid && (tx_line_data == $past(tx_bit_in));
	endsequence
	sequence s_plain;
		tx_bit_valid && !c_los && !c_ais && !c_idle;
	endsequence

	property p_yellow_zero;
		s_plain and (tx_bit_kind == DTXA_KIND_X && c_yel) |-> s_zero_out;
	endproperty
	a_yellow_zero: assert property (p_yellow_zero)
		else $error("forced yellow did not zero X-bit");
	property p_yellow_ignored;
		tx_bit_valid && c_idle && !c_los && !c_ais && c_yel
			&& tx_bit_kind == DTXA_KIND_X |-> s_one_out;
	endproperty
	a_yellow_ignored: assert property (p_yellow_ignored)
		else $error("yellow force acted during idle");
	property p_xhigh_one;
		s_plain and (tx_bit_kind == DTXA_KIND_X && c_xhi && !c_yel) |-> s_one_out;
	endproperty
	a_xhigh_one: assert property (p_xhigh_one)
		else $error("X-high force not applied");
	property p_xhigh_ignored;
		tx_bit_valid && c_xhi && tx_bit_kind == DTXA_KIND_X
			&& (c_los || (c_yel && !c_ais && !c_idle)) |-> s_zero_out;
	endproperty
	a_xhigh_ignored: assert property (p_xhigh_ignored)
		else $error("X-high force beat loss-of-signal or yellow");
	property p_idle_fill;
		tx_bit_valid && c_idle && !c_los && !c_ais && tx_bit_kind == DTXA_KIND_PAYLOAD
			|-> ##1 tx_line_data == !$past(pat_cnt_reg[1]);
	endproperty
	a_idle_fill: assert property (p_idle_fill)
		else $error("idle payload not 1100");
	property p_idle_cp;
		tx_bit_valid && c_idle && !c_los && !c_ais && tx_bit_kind == DTXA_KIND_CP
			|-> s_zero_out;
	endproperty
	a_idle_cp: assert property (p_idle_cp)
		else $error("idle CP bit not zero");
	property p_idle_under_ais;
		tx_bit_valid && c_idle && c_ais && !c_los && tx_bit_kind == DTXA_KIND_PAYLOAD
			&& pat_cnt_reg == 2'h1 |-> s_zero_out;
	endproperty
	a_idle_under_ais: assert property (p_idle_under_ais)
		else $error("idle pattern won over AIS");
	property p_ais_fill;
		tx_bit_valid && c_ais && !c_los && tx_bit_kind == DTXA_KIND_PAYLOAD
			|-> ##1 tx_line_data == !$past(pat_cnt_reg[0]);
	endproperty
	a_ais_fill: assert property (p_ais_fill)
		else $error("AIS payload not 1010");
	property p_ais_mfp;
		tx_bit_valid && c_ais && !c_los && tx_bit_kind == DTXA_KIND_MFP |-> s_pass_out;
	endproperty
	a_ais_mfp: assert property (p_ais_mfp)
		else $error("AIS frame lost framing bits");
	property p_los_zero;
		tx_bit_valid && c_los |-> s_zero_out;
	endproperty
	a_los_zero: assert property (p_los_zero)
		else $error("line marked during loss-of-signal");
	property p_normal_pass;
		s_plain and (tx_bit_kind != DTXA_KIND_X) |-> s_pass_out;
	endproperty
	a_normal_pass: assert property (p_normal_pass)
		else $error("normal bit altered");
	property p_auto_los;
		s_plain and (tx_bit_kind == DTXA_KIND_X && !c_xhi && rx_los
			&& cfg_reg[`DTXA_BIT_ON_LOS]) |-> s_zero_out;
	endproperty
	a_auto_los: assert property (p_auto_los)
		else $error("no yellow on receive LOS");
	property p_auto_oof;
		s_plain and (tx_bit_kind == DTXA_KIND_X && !c_xhi && rx_oof
			&& cfg_reg[`DTXA_BIT_ON_OOF]) |-> s_zero_out;
	endproperty
	a_auto_oof: assert property (p_auto_oof)
		else $error("no yellow on receive OOF");
	property p_auto_ais;
		s_plain and (tx_bit_kind == DTXA_KIND_X && !c_xhi && rx_ais
			&& cfg_reg[`DTXA_BIT_ON_AIS]) |-> s_zero_out;
	endproperty
	a_auto_ais: assert property (p_auto_ais)
		else $error("no yellow on receive AIS");
	property p_auto_off;
		s_plain and (tx_bit_kind == DTXA_KIND_X && !c_yel && !(cfg_reg[2:0] != 3'h0))
			|-> s_one_out;
	endproperty
	a_auto_off: assert property (p_auto_off)
		else $error("yellow sent with enables off");
	property p_los_over_ais;
		tx_bit_valid && c_los && c_ais && tx_bit_kind == DTXA_KIND_X |-> s_zero_out;
	endproperty
	a_los_over_ais: assert property (p_los_over_ais)
		else $error("AIS pattern beat loss-of-signal");

endmodule

`default_nettype wire

/* dtxa_override_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`include "dtxa_defines.svh"
`define DTXA_CHK(g, e) begin total_checks++; if ((g) !== (e)) begin fail_count++; \
$display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end

module dtxa_override_tb;
	import dtxa_pkg::*;
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	logic reg_wr_en = 1'b0;
	logic reg_rd_en = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [7:0] reg_wr_data = 8'h00;
	logic rx_los = 1'b0;
	logic rx_oof = 1'b0;
	logic rx_ais = 1'b0;
	logic tx_bit_valid = 1'b0;
	logic tx_bit_in = 1'b0;
	dtxa_kind_t tx_bit_kind = DTXA_KIND_PAYLOAD;
	logic [7:0] reg_rd_data;
	logic tx_line_valid;
	logic tx_line_data;
	logic tx_yellow_active;
	logic [15:0] liu_count;
	logic liu_marks;
	int fail_count = 0;
	int total_checks = 0;
	int sent = 0;
	logic [7:0] cfg = 8'h07; // mirror of the configuration register
	logic [1:0] cnt = 2'h0; // mirror of the fill counter
	logic pend = 1'b0;
	logic pend_exp = 1'b0;

	dtxa_override i_dut (.sys_clk(sys_clk), .rst(rst), .reg_wr_en(reg_wr_en),
		.reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_wr_data(reg_wr_data),
		.reg_rd_data(reg_rd_data), .rx_los(rx_los), .rx_oof(rx_oof), .rx_ais(rx_ais),
		.tx_bit_valid(tx_bit_valid), .tx_bit_in(tx_bit_in), .tx_bit_kind(tx_bit_kind),
		.tx_line_valid(tx_line_valid), .tx_line_data(tx_line_data),
		.tx_yellow_active(tx_yellow_active));

	dtxa_liu_model i_liu (.sys_clk(sys_clk), .rst(rst), .line_valid(tx_line_valid),
		.line_data(tx_line_data), .bit_count(liu_count), .idle_marks(liu_marks));

	// ****
	// reference model
	// ****
	// expected line bit for a given setting, class and fill position
	function automatic logic exp_bit(logic [7:0] c, dtxa_kind_t k, logic b, logic [1:0] n);
		logic [3:0] s;
		logic auto_y;
		s = c[4] ? `DTXA_AIS_SEQ : `DTXA_IDLE_SEQ;
		auto_y = (c[2] & rx_los) | (c[1] & rx_oof) | (c[0] & rx_ais);
		if (c[3])
			return 1'b0;
		if (c[4] | c[5])
		begin
			if (k == DTXA_KIND_X)
				return 1'b1;
			if (k == DTXA_KIND_PAYLOAD)
				return s[3 - n];
			if (k == DTXA_KIND_CP || (k == DTXA_KIND_C && c[4]))
				return 1'b0;
			return b;
		end
		if (k == DTXA_KIND_X)
			return !c[7] & (c[6] | !auto_y);
		return b;
	endfunction

	// ****
	// bus and stream tasks
	// ****
	// outputs lag one edge, so each bit is judged when the next one goes in
	task automatic send_bit(dtxa_kind_t k, logic b);
		@(posedge sys_clk);
		tx_bit_valid <= 1'b1;
		tx_bit_kind <= k;
		tx_bit_in <= b;
		@(negedge sys_clk);
		if (pend) `DTXA_CHK({tx_line_valid, tx_line_data}, {1'b1, pend_exp})
		pend = 1'b1;
		pend_exp = exp_bit(cfg, k, b, cnt);
		if (k == DTXA_KIND_PAYLOAD)
			cnt++;
		sent++;
	endtask

	task automatic flush;
		@(posedge sys_clk);
		tx_bit_valid <= 1'b0;
		@(negedge sys_clk);
		if (pend) `DTXA_CHK({tx_line_valid, tx_line_data}, {1'b1, pend_exp})
		pend = 1'b0;
	endtask

	task automatic reg_wr(logic [7:0] a, logic [7:0] d);
		flush;
		@(posedge sys_clk);
		reg_wr_en <= 1'b1;
		reg_addr <= a;
		reg_wr_data <= d;
		@(posedge sys_clk);
		reg_wr_en <= 1'b0;
		if (a == `DTXA_CFG_ADDR)
			cfg = d;
	endtask

	task automatic reg_rd(logic [7:0] a, logic [7:0] e);
		@(posedge sys_clk);
		reg_rd_en <= 1'b1;
		reg_addr <= a;
		@(posedge sys_clk);
		reg_rd_en <= 1'b0;
		@(negedge sys_clk);
		`DTXA_CHK(reg_rd_data, e)
	endtask

	task automatic chk_yellow;
		logic e;
		repeat (2) @(posedge sys_clk);
		@(negedge sys_clk);
		e = (cfg[5:3] == 3'h0) && !exp_bit(cfg, DTXA_KIND_X, 1'b0, 2'h0);
		`DTXA_CHK(tx_yellow_active, e)
	endtask

	// ****
	// scenarios
	// ****
	// reset value, unmapped place refused, read back
	task automatic t_regs;
		reg_rd(`DTXA_CFG_ADDR, `DTXA_CFG_RESET);
		reg_wr(8'h31, 8'hff);
		reg_rd(8'h31, `DTXA_RD_ZERO);
		reg_rd(`DTXA_CFG_ADDR, `DTXA_CFG_RESET);
		reg_wr(`DTXA_CFG_ADDR, 8'ha5);
		reg_rd(`DTXA_CFG_ADDR, 8'ha5);
	endtask

	// forced and receiver-driven x-bits in every receiver state
	task automatic t_xbits;
		logic [7:0] l [9] = '{8'h00, 8'h80, 8'h40, 8'hc0, 8'h04, 8'h02, 8'h01, 8'h47, 8'h87};
		foreach (l[i])
			for (int r = 0; r < 8; r++)
			begin
				reg_wr(`DTXA_CFG_ADDR, l[i]);
				@(posedge sys_clk);
				{rx_los, rx_oof, rx_ais} <= 3'(r);
				send_bit(DTXA_KIND_X, 1'b0);
				send_bit(DTXA_KIND_X, 1'b1);
				send_bit(DTXA_KIND_PAYLOAD, 1'b1);
				flush;
				chk_yellow;
			end
	endtask

	// pattern commands alone and stacked, then back to normal
	task automatic t_modes;
		logic [7:0] l [12] = '{8'h20, 8'ha0, 8'h60, 8'he7, 8'h10, 8'h30, 8'hb0, 8'h08,
			8'h18, 8'h38, 8'hf8, 8'h00};
		foreach (l[i])
		begin
			reg_wr(`DTXA_CFG_ADDR, l[i]);
			for (int k = 0; k < 10; k++)
				send_bit(dtxa_kind_t'(3'(k / 2)), 1'(k));
			for (int p = 0; p < 6; p++)
				send_bit(DTXA_KIND_PAYLOAD, 1'(p));
			flush;
			chk_yellow;
		end
	endtask

	task automatic test_done;
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// free-running clock
	initial
	begin
		forever #2 sys_clk = ~sys_clk;
	end

	// watchdog, far beyond the roughly one thousand cycles the run needs
	initial
	begin
		#100000;
		fail_count++;
		test_done;
	end

	// main sequence
	initial
	begin
		repeat (12) @(posedge sys_clk);
		rst <= 1'b0;
		t_regs;
		t_xbits;
		t_modes;
		repeat (2) @(posedge sys_clk);
		@(negedge sys_clk);
		`DTXA_CHK(liu_count, sent[15:0])
		`DTXA_CHK(liu_marks, 1'b0)
		test_done;
	end
endmodule

`default_nettype wire

/* dtxa_pkg.sv */
`default_nettype none

package dtxa_pkg;

	// ****************************************
	// outbound bit classes, tagged by the framer upstream
	// ****************************************
	typedef enum logic [2:0]
	{
		DTXA_KIND_PAYLOAD = 3'h0,
		DTXA_KIND_MFP = 3'h1,
		DTXA_KIND_X = 3'h2,
		DTXA_KIND_C = 3'h3,
		DTXA_KIND_CP = 3'h4
	} dtxa_kind_t;

	// ****************************************
	// transmit override modes, one-hot
	// ****************************************
	typedef enum logic [3:0]
	{
		DTXA_MODE_NORMAL = 4'h1,
		DTXA_MODE_IDLE = 4'h2,
		DTXA_MODE_AIS = 4'h4,
		DTXA_MODE_LOS = 4'h8
	} dtxa_mode_t;

endpackage

`default_nettype wire
